// ===== common/msad_pkg.sv
// Constants and carrier types for the memory space address decoder
// Operation
// R1 - Program addresses 24-bit, from 23-bit counter
// R2 - User range lower half; config needs page bit7
// R3 - Program word: even lower, odd upper word
// R4 - Counter word aligned, steps by two
// R5 - Fetch starts at zero after reset
// R6 - Primary and alternate vector tables decoded
// R7 - Separate read and write address units
// R8 - Data addresses 16-bit, byte granular
// R9 - Top address bit selects visibility window
// R10 - Outside implemented data reads return zero
// R11 - Low byte even, high byte odd
// R12 - Byte read selects lane, lands low
// R13 - Byte write strobes matching lane only
// R14 - Post-increment by one byte, two word
// R15 - Odd word access raises address trap
// R16 - Misaligned read completes; write suppressed
// R17 - Byte load updates only low byte
// R18 - Sign and zero extension of bytes
// R19 - Lowest 2 KB decoded as function registers
// R20 - Unused function register reads return zero
// R21 - Near area reachable by 13-bit field
// R22 - Whole space via 16-bit direct or pointer
// R23 - Upper half maps via 8-bit page register
// R24 - Window active only while enable bit set
// R25 - Unimplemented user program reads return zero; the code passes fetch_data_i for every user address instead
package msad_pkg;

    // ****************************************
    // Program space
    // ****************************************
    localparam int          PADDR_W        = 24;
    localparam int          PC_W           = 23;
    localparam logic [23:0] RESET_ADDR     = 24'h000000;
    localparam logic [23:0] RESET_TARGET   = 24'h000002;
    localparam logic [23:0] IVT_LO         = 24'h000004;
    localparam logic [23:0] AIVT_LO        = 24'h000100;
    localparam logic [23:0] AIVT_HI        = 24'h0001FF;
    localparam logic [23:0] USER_HI        = 24'h7FFFFF;
    localparam int          CFG_PAGE_BIT   = 7;
    localparam logic [22:0] PC_STEP        = 23'h000002;

    // ****************************************
    // Data space
    // ****************************************
    localparam int          DADDR_W        = 16;
    localparam logic [15:0] SFR_HI         = 16'h07FF;
    localparam logic [15:0] NEAR_HI        = 16'h1FFF;
    localparam int          NEAR_FIELD_W   = 13;
    localparam int          WIN_BIT        = 15;
    localparam logic [15:0] INC_BYTE       = 16'h0001;
    localparam logic [15:0] INC_WORD       = 16'h0002;

    typedef enum logic [1:0] {
        MSAD_REG_NONE = 2'h0,
        MSAD_REG_SE   = 2'h1,
        MSAD_REG_ZE   = 2'h3
    } msad_ext_t;

    typedef struct packed {
        logic        valid;
        logic        is_byte;
        logic        post_inc;
        logic [15:0] addr;
        logic [15:0] data;
    } msad_acc_t;

    typedef struct packed {
        logic        valid;
        logic        table_op;
        logic [7:0]  table_page;
        logic [15:0] offset;
    } msad_preq_t;

endpackage

// ===== src/msad_decoder.sv
// Program and data space address decoder with alignment handling
`timescale 1ns/100ps
module msad_decoder #(
    parameter int DRAM_BYTES = 8192,
    parameter int SFR_WORDS  = 64
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  srst_i,
    // Fetch unit
    input  wire logic                  pc_step_i,
    input  wire logic                  pc_back_i,
    input  wire logic                  pc_load_i,
    input  wire logic [22:0]           pc_load_val_i,
    input  wire logic [23:0]           fetch_data_i,
    output logic      [23:0]           prog_addr_o,
    output logic      [23:0]           instr_o,
    output logic                       vec_primary_o,
    output logic                       vec_alt_o,
    // Table and visibility requests
    input  msad_pkg::msad_preq_t       preq_i,
    output logic                       preq_ok_o,
    output logic                       preq_upper_o,
    output logic      [23:0]           preq_addr_o,
    // Control bits
    input  wire logic [7:0]            visibility_page_register_i,
    input  wire logic                  psv_enable_i,
    // Read address unit
    input  msad_pkg::msad_acc_t        rd_i,
    input  wire logic                  rd_sign_ext_i,
    input  wire logic                  rd_zero_ext_i,
    input  wire logic [15:0]           wreg_old_i,
    input  wire logic [15:0]           sfr_rdata_i,
    input  wire logic [15:0]           sfr_used_i,
    output logic      [15:0]           rd_data_o,
    output logic      [15:0]           rd_ptr_o,
    output logic                       rd_sfr_o,
    output logic                       rd_psv_o,
    output logic      [23:0]           rd_psv_addr_o,
    // Write address unit
    input  msad_pkg::msad_acc_t        wr_i,
    output logic      [15:0]           wr_ptr_o,
    output logic      [1:0]            wr_lane_o,
    output logic      [15:0]           wr_data_o,
    output logic                       wr_sfr_o,
    output logic                       addr_trap_o
);
    if (DRAM_BYTES < 2048 || DRAM_BYTES > 8192 || DRAM_BYTES % 2 != 0) begin : g_bad_size
        $error("DRAM_BYTES out of range");
    end

    localparam int DW = DRAM_BYTES / 2;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] next_ptr(input logic [15:0] a, input logic b);
        next_ptr = a + (b ? msad_pkg::INC_BYTE : msad_pkg::INC_WORD); // R14
    endfunction

    function automatic logic misaligned(input msad_pkg::msad_acc_t x);
        misaligned = x.valid && !x.is_byte && x.addr[0]; // R15
    endfunction

    logic [15:0] dram_r [DW];
    logic [22:0] pc_r;
    logic        rd_bad;
    logic        wr_bad;
    logic [15:0] rword;
    logic [7:0]  rbyte;
    logic [15:0] rval;

    // ****************************************
    // Program counter and fetch
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pc_r <= msad_pkg::RESET_ADDR[22:0]; // R5
        end else if (pc_load_i) begin
            pc_r <= {pc_load_val_i[22:1], 1'b0}; // R4
        end else if (pc_step_i) begin
            pc_r <= pc_r + msad_pkg::PC_STEP; // R4
        end else if (pc_back_i) begin
            pc_r <= pc_r - msad_pkg::PC_STEP; // R4
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            prog_addr_o   <= 24'h000000;
            instr_o       <= 24'h000000;
            vec_primary_o <= 1'b0;
            vec_alt_o     <= 1'b0;
        end else begin
            prog_addr_o   <= {1'b0, pc_r}; // R1
            // Upper byte of the odd word is absent: only 24 bits exist
            instr_o       <= ({1'b0, pc_r} <= msad_pkg::USER_HI) ? fetch_data_i
                                                                 : 24'h000000; // R3 R25
            vec_primary_o <= {1'b0, pc_r} >= msad_pkg::IVT_LO
                          && {1'b0, pc_r} <  msad_pkg::AIVT_LO; // R6
            vec_alt_o     <= {1'b0, pc_r} >= msad_pkg::AIVT_LO
                          && {1'b0, pc_r} <= msad_pkg::AIVT_HI; // R6
        end
    end

    // ****************************************
    // Table access gate
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            preq_ok_o    <= 1'b0;
            preq_upper_o <= 1'b0;
            preq_addr_o  <= 24'h000000;
        end else begin
            preq_addr_o  <= {preq_i.table_page, preq_i.offset}; // R1
            preq_upper_o <= preq_i.offset[0]; // R3
            // Config area only through a table op with page bit 7
            preq_ok_o    <= preq_i.valid && (!preq_i.table_page[msad_pkg::CFG_PAGE_BIT]
                          || preq_i.table_op); // R2
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    assign rd_bad = misaligned(rd_i);
    assign wr_bad = misaligned(wr_i);

    always_comb begin
        rword = 16'h0000;
        if (!rd_i.addr[msad_pkg::WIN_BIT]) begin // R9
            if (rd_i.addr <= msad_pkg::SFR_HI) begin
                rword = sfr_used_i[rd_i.addr[4:1]] ? sfr_rdata_i : 16'h0000; // R19 R20
            end else if (rd_i.addr < 16'(DRAM_BYTES)) begin
                rword = dram_r[rd_i.addr[$clog2(DW):1]]; // R10 R22
            end
        end
        rbyte = rd_i.addr[0] ? rword[15:8] : rword[7:0]; // R11 R12
        if (!rd_i.is_byte) begin
            rval = rword;
        end else if (rd_sign_ext_i) begin
            rval = {{8{rbyte[7]}}, rbyte}; // R18
        end else if (rd_zero_ext_i) begin
            rval = {8'h00, rbyte}; // R18
        end else begin
            rval = {wreg_old_i[15:8], rbyte}; // R17
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rd_data_o       <= 16'h0000;
            rd_ptr_o        <= 16'h0000;
            rd_sfr_o        <= 1'b0;
            rd_psv_o        <= 1'b0;
            rd_psv_addr_o   <= 24'h000000;
        end else if (rd_i.valid) begin
            // Read completes even when misaligned
            rd_data_o       <= rval; // R16
            rd_ptr_o        <= rd_i.post_inc ? next_ptr(rd_i.addr, rd_i.is_byte)
                                             : rd_i.addr; // R7 R8 R14
            rd_sfr_o        <= rd_i.addr <= msad_pkg::SFR_HI; // R19
            rd_psv_o        <= rd_i.addr[msad_pkg::WIN_BIT] && psv_enable_i; // R9 R24
            rd_psv_addr_o   <= {1'b0, visibility_page_register_i, rd_i.addr[14:0]}; // R23
        end
    end

    // ****************************************
    // Write path
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wr_ptr_o  <= 16'h0000;
            wr_lane_o <= 2'b00;
            wr_data_o <= 16'h0000;
            wr_sfr_o  <= 1'b0;
        end else begin
            wr_ptr_o  <= wr_i.valid && wr_i.post_inc ? next_ptr(wr_i.addr, wr_i.is_byte)
                                                     : wr_i.addr; // R7 R14
            if (!wr_i.valid || wr_bad) begin
                wr_lane_o <= 2'b00; // R16
            end else if (wr_i.is_byte) begin
                wr_lane_o <= wr_i.addr[0] ? 2'b10 : 2'b01; // R13
            end else begin
                wr_lane_o <= 2'b11;
            end
            wr_data_o <= wr_i.is_byte ? {wr_i.data[7:0], wr_i.data[7:0]} : wr_i.data; // R11
            wr_sfr_o  <= wr_i.valid && !wr_bad && wr_i.addr <= msad_pkg::SFR_HI;
        end
    end

    // No reset on storage: contents are undefined after reset
    always_ff @(posedge ref_clk_i) begin
        if (wr_i.valid && !wr_bad && !wr_i.addr[msad_pkg::WIN_BIT]
            && wr_i.addr > msad_pkg::SFR_HI && wr_i.addr < 16'(DRAM_BYTES)) begin
            if (!wr_i.is_byte || !wr_i.addr[0])
                dram_r[wr_i.addr[$clog2(DW):1]][7:0]  <= wr_i.data[7:0]; // R13
            if (!wr_i.is_byte || wr_i.addr[0])
                dram_r[wr_i.addr[$clog2(DW):1]][15:8] <= wr_i.is_byte ? wr_i.data[7:0]
                                                             : wr_i.data[15:8]; // R13
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            addr_trap_o <= 1'b0;
        end else begin
            addr_trap_o <= rd_bad || wr_bad; // R15 R16
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    trap_odd_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R15
        (wr_i.valid && !wr_i.is_byte && wr_i.addr[0]) |=> addr_trap_o)
        else $error("odd word write without trap");

    write_block_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R16
        addr_trap_o && $past(wr_bad) |-> wr_lane_o == 2'b00)
        else $error("misaligned store not suppressed");

    byte_lane_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R13
        (wr_i.valid && wr_i.is_byte && !wr_i.addr[0]) |=> wr_lane_o == 2'b01)
        else $error("wrong byte lane");

    post_inc_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R14
        (rd_i.valid && rd_i.post_inc && !rd_i.is_byte) |=>
        rd_ptr_o == $past(rd_i.addr) + 16'h0002)
        else $error("word post increment wrong");

    pc_step_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R4
        (pc_step_i && !pc_load_i) |=> pc_r == $past(pc_r) + 23'h000002)
        else $error("counter step wrong");

    pc_even_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R4
        !pc_r[0]) else $error("counter not aligned");

    psv_gate_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R24
        (rd_i.valid && !psv_enable_i) |=> !rd_psv_o)
        else $error("window active while disabled");

    zero_hole_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R10
        (rd_i.valid && !rd_i.addr[15] && rd_i.addr >= 16'(DRAM_BYTES) && !rd_i.is_byte)
        |=> rd_data_o == 16'h0000)
        else $error("hole read not zero");

    cfg_gate_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R2
        (preq_i.valid && preq_i.table_page[7] && !preq_i.table_op) |=> !preq_ok_o)
        else $error("config reached without table op");

    byte_high_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R13
        (wr_i.valid && wr_i.is_byte && wr_i.addr[0]) |=> wr_lane_o == 2'b10)
        else $error("wrong high byte lane");

    near_write_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R21
        (wr_i.valid && !wr_i.is_byte && !wr_i.addr[0] && wr_i.addr <= msad_pkg::NEAR_HI)
        |=> wr_lane_o == 2'b11)
        else $error("near word write not strobed");

    read_trap_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R15
        (rd_i.valid && !rd_i.is_byte && rd_i.addr[0]) |=> addr_trap_o)
        else $error("odd word read without trap");

    byte_inc_a: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R14
        (rd_i.valid && rd_i.post_inc && rd_i.is_byte) |=>
        rd_ptr_o == $past(rd_i.addr) + 16'h0001)
        else $error("byte post increment wrong");

endmodule

// ===== testbench/msad_core_model.sv
// Far-side model: program flash words and function register contents
`timescale 1ns/100ps
module msad_core_model #(
    parameter logic [23:0] JUMP_WORD = 24'h040000
) (
    // Program address from the decoder; read address as driven to its read unit
    input  wire logic [23:0] prog_addr_i,
    input  wire logic [15:0] rd_addr_i,
    // Data returned
    output logic      [23:0] fetch_data_o,
    output logic      [15:0] sfr_rdata_o
);
    // Words differ with the low 16 address bits so a stale fetch shows
    always_comb begin
        if (prog_addr_i == 24'h000000) begin
            fetch_data_o = JUMP_WORD;
        end else if (prog_addr_i == 24'h000002) begin
            fetch_data_o = 24'h000200;
        end else begin
            fetch_data_o = {prog_addr_i[7:0], prog_addr_i[15:0] ^ 16'hC35A};
        end
    end
    assign sfr_rdata_o = rd_addr_i ^ 16'h5AA5;
endmodule

// ===== testbench/memory_space_address_decoder_test.sv
// Self-checking bench for the address decoder
`timescale 1ns/100ps
module memory_space_address_decoder_test;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic pc_step_i = 1'b0, pc_back_i = 1'b0, pc_load_i = 1'b0;
    logic [22:0] pc_load_val_i = '0;
    logic [23:0] fetch_data_i, prog_addr_o, instr_o, preq_addr_o, rd_psv_addr_o, ep;
    logic vec_primary_o, vec_alt_o, preq_ok_o, preq_upper_o, rd_sfr_o, rd_psv_o;
    logic wr_sfr_o, addr_trap_o, psv_enable_i = 1'b0;
    logic rd_sign_ext_i = 1'b0, rd_zero_ext_i = 1'b0;
    msad_pkg::msad_preq_t preq_i = '0;
    msad_pkg::msad_acc_t rd_i = '0, wr_i = '0;
    logic [7:0] visibility_page_register_i = '0, b;
    logic [15:0] wreg_old_i = '0, sfr_used_i = '0, sfr_rdata_i;
    logic [15:0] rd_data_o, rd_ptr_o, wr_ptr_o, wr_data_o, a, d, e;
    logic [1:0] wr_lane_o;
    logic [2:0] op;
    logic [22:0] v;
    int fail_count = 0, num_checks = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    msad_decoder dut_u (.ref_clk_i, .srst_i, .pc_step_i, .pc_back_i, .pc_load_i,
        .pc_load_val_i, .fetch_data_i, .prog_addr_o, .instr_o, .vec_primary_o, .vec_alt_o,
        .preq_i, .preq_ok_o, .preq_upper_o, .preq_addr_o, .visibility_page_register_i,
        .psv_enable_i, .rd_i, .rd_sign_ext_i, .rd_zero_ext_i, .wreg_old_i, .sfr_rdata_i,
        .sfr_used_i, .rd_data_o, .rd_ptr_o, .rd_sfr_o, .rd_psv_o, .rd_psv_addr_o, .wr_i,
        .wr_ptr_o, .wr_lane_o, .wr_data_o, .wr_sfr_o, .addr_trap_o);

    msad_core_model model_u (.prog_addr_i(prog_addr_o), .rd_addr_i(rd_i.addr),
        .fetch_data_o(fetch_data_i), .sfr_rdata_o(sfr_rdata_i));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic msad_pkg::msad_acc_t mk(input logic bt, input logic [15:0] ad,
                                               input logic [15:0] dt);
        mk = '{1'b1, bt, 1'b1, ad, dt};
    endfunction

    // Expected flash word for a program address, as the partner model returns it
    function automatic logic [23:0] fw(input logic [23:0] p);
        fw = (p == 24'h0) ? 24'h040000 : (p == 24'h2) ? 24'h000200
                                       : {p[7:0], p[15:0] ^ 16'hC35A};
    endfunction

    // Read and write units driven in the same cycle; one idle cycle after
    task automatic acc(input msad_pkg::msad_acc_t r, input msad_pkg::msad_acc_t w,
                       input logic [1:0] x);
        @(posedge ref_clk_i);
        rd_i <= r;
        wr_i <= w;
        rd_sign_ext_i <= x[1];
        rd_zero_ext_i <= x[0];
        @(posedge ref_clk_i);
        rd_i.valid <= 1'b0;
        wr_i.valid <= 1'b0;
        #1;
    endtask

    // Vector flags lag the counter, fetched word one edge more
    task automatic pc_op(input logic [2:0] o, input logic [22:0] val);
        @(posedge ref_clk_i);
        {pc_load_i, pc_step_i, pc_back_i} <= o;
        pc_load_val_i <= val;
        @(posedge ref_clk_i);
        {pc_load_i, pc_step_i, pc_back_i} <= 3'h0;
        @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        #1;
    endtask

    initial begin
        #500000;
        fail_count++;
        final_report();
    end

    initial begin
        void'($urandom(48231));
        repeat (8) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk(prog_addr_o, 24'h000000);
        chk(instr_o, 24'h040000);
        pc_op(3'h4, 23'h0000FF);
        chk(prog_addr_o, 24'h0000FE);
        chk({vec_alt_o, vec_primary_o}, 2'h1);
        pc_op(3'h3, 23'h0);
        chk(prog_addr_o, 24'h000100);
        chk({vec_alt_o, vec_primary_o}, 2'h2);
        ep = 24'h000100;
        for (int i = 0; i < 8; i++) begin
            op = 3'h1 << ($urandom % 3);
            v = 23'($urandom);
            pc_op(op, v);
            ep = op[2] ? {1'b0, v[22:1], 1'b0}
                       : {1'b0, ep[22:0] + (op[1] ? 23'h2 : 23'h7FFFFE)};
            chk(prog_addr_o, ep);
            chk(instr_o, fw(ep));
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_i);
            preq_i <= {1'b1, i[0], i[1], 7'($urandom), 16'($urandom)};
            @(posedge ref_clk_i);
            preq_i.valid <= 1'b0;
            #1;
            chk(preq_ok_o, !i[1] || i[0]);
            chk(preq_addr_o, {preq_i.table_page, preq_i.offset});
            chk(preq_upper_o, preq_i.offset[0]);
        end
        for (int i = 0; i < 3; i++) begin
            a = 16'h0800 | (16'($urandom) & 16'h17FE);
            d = 16'($urandom);
            b = 8'($urandom);
            wreg_old_i <= 16'($urandom);
            acc('0, mk(1'b0, a, d), 2'h0);
            chk({addr_trap_o, wr_lane_o}, 3'h3);
            chk(wr_ptr_o, a + 16'h2);
            chk(wr_data_o, d);
            acc(mk(1'b0, a, 16'h0), '0, 2'h0);
            chk(rd_data_o, d);
            chk(rd_ptr_o, a + 16'h2);
            acc(mk(1'b1, a, 16'h0), '0, 2'h2);
            chk(rd_data_o, {{8{d[7]}}, d[7:0]});
            chk(rd_ptr_o, a + 16'h1);
            acc(mk(1'b1, a, 16'h0), '0, 2'h1);
            chk(rd_data_o, {8'h00, d[7:0]});
            acc('0, mk(1'b1, a + 16'h1, {b, b}), 2'h0);
            chk(wr_lane_o, 2'h2);
            chk(wr_data_o, {b, b});
            chk(wr_ptr_o, a + 16'h2);
            acc(mk(1'b1, a + 16'h1, 16'h0), '0, 2'h0);
            chk(rd_data_o, {wreg_old_i[15:8], b});
            acc('0, mk(1'b0, a + 16'h1, ~d), 2'h0);
            chk({addr_trap_o, wr_lane_o}, 3'h4);
            acc(mk(1'b0, a, 16'h0), '0, 2'h0);
            chk(rd_data_o, {b, d[7:0]});
            acc(mk(1'b0, a + 16'h1, 16'h0), '0, 2'h0);
            chk(addr_trap_o, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            a = 16'($urandom) & 16'h07FE;
            sfr_used_i <= 16'($urandom);
            acc(mk(1'b0, a, 16'h0), mk(1'b0, a, 16'h0), 2'h0);
            e = sfr_used_i[a[4:1]] ? (a ^ 16'h5AA5) : 16'h0;
            chk(rd_data_o, e);
            chk({rd_sfr_o, wr_sfr_o}, 2'h3);
            a = 16'h2000 | (16'($urandom) & 16'h5FFE);
            acc(mk(1'b0, a, 16'h0), '0, 2'h0);
            chk({rd_psv_o, rd_data_o}, 17'h0);
            a = 16'h8000 | (16'($urandom) & 16'h7FFE);
            psv_enable_i <= i[0];
            visibility_page_register_i <= 8'($urandom);
            acc(mk(1'b0, a, 16'h0), '0, 2'h0);
            chk({rd_psv_o, rd_data_o}, {i[0], 16'h0});
            if (i[0]) begin
                chk(rd_psv_addr_o, {1'b0, visibility_page_register_i, a[14:0]});
            end
        end
        final_report();
    end
endmodule
